// ### dv/tps_ext_src.sv
// Purpose: Source driving the external count clock pin
// Assumes: Bench calls burst from its main sequence
// Notes: Pin idles low between bursts
module tps_ext_src (
  input wire logic sys_clk,
  output logic pin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial pin = 1'b0;
  // High level held three timer clocks, low level four
  task automatic burst(int n);
    repeat (n) begin
      @(negedge sys_clk) pin = 1'b1;
      repeat (3) @(negedge sys_clk);
      pin = 1'b0;
      repeat (3) @(negedge sys_clk);
    end
  endtask
endmodule

// ### dv/tps_top_assertions.sv
// Purpose: Port checks for tps_top
// Assumes: Bound to every tps_top
// Notes: One clock domain
module tps_top_assertions
  import tps_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [3:0] timer_output_disable_reg,
  input wire logic fixed_period_pwm_select,
  input wire logic [1:0] combo_mode_field,
  input wire logic pwm_mode_select_c,
  input wire logic pwm_mode_select_d,
  input wire logic [2:0] io_ctrl_a,
  input wire logic [2:0] io_ctrl_c,
  input wire logic cutoff_input_enable,
  input wire logic int_edge_mode_sel,
  input wire logic ext_irq_enable,
  input wire logic irq_pin_direction,
  input wire logic ext_interrupt_pin,
  input wire logic [2:0] clock_source_sel_ch0,
  input wire logic [2:0] clock_source_sel_ch1,
  input wire logic [4:0] div_tick,
  input wire logic fast_osc_enable,
  input wire logic fast_osc_tick,
  input tps_func_e pin_func_a,
  input tps_func_e pin_func_c,
  input tps_func_e pin_func_d,
  input wire logic [3:0] pin_out_en,
  input wire logic cutoff_mode,
  input wire logic count_en_ch0,
  input wire logic count_en_ch1
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  wire logic [3:0] od = timer_output_disable_reg;
  wire logic tm = fixed_period_pwm_select && combo_mode_field == 2'h0;
  wire logic fp = !fixed_period_pwm_select && combo_mode_field == 2'h0;
  wire logic cut = cutoff_input_enable && !int_edge_mode_sel &&
    ext_irq_enable && !irq_pin_direction;
  wire logic rs = combo_mode_field == 2'h1;
  a_cut_mode: assert property (1 |=> cutoff_mode == $past(cut))
    else $error("cutoff mode wrong");
  a_cut_disable: assert property (cut && !ext_interrupt_pin |=>
    od == 4'hf ##1 pin_out_en == 4'h0) else $error("cutoff late");
  a_comb_out: assert property (!od[2] && combo_mode_field[1] |=>
    pin_func_c == TPS_FN_COMP) else $error("complementary missing");
  a_rsync_out: assert property (!od[3] && rs |=>
    pin_func_d == TPS_FN_RSYNC && pin_out_en[3])
    else $error("rsync missing");
  a_oc_out: assert property (!od[0] && tm && !io_ctrl_a[2] &&
    io_ctrl_a != 3'h0 |=> pin_func_a == TPS_FN_OC)
    else $error("compare missing");
  a_ic_input: assert property (tm && !pwm_mode_select_c &&
    io_ctrl_c[2] |=> pin_func_c == TPS_FN_IC && !pin_out_en[2])
    else $error("capture bad");
  a_pwm_out: assert property (!od[3] && tm && pwm_mode_select_d
    |=> pin_func_d == TPS_FN_PWM) else $error("pwm missing");
  a_fixed_port: assert property (fp |=> pin_func_a == TPS_FN_PORT)
    else $error("fixed period not port");
  a_div_sel: assert property (clock_source_sel_ch0 == 3'h3 |=>
    count_en_ch0 == $past(div_tick[3])) else $error("f8 count bad");
  a_fosc_sel: assert property (clock_source_sel_ch1 == 3'h6 |=>
    count_en_ch1 == $past(fast_osc_tick && fast_osc_enable))
    else $error("fast osc count bad");
  a_no_ext: assert property (fp && clock_source_sel_ch0 == 3'h5
    |=> !count_en_ch0) else $error("ext clock in fixed period");
  c_cut: cover property (cut && !ext_interrupt_pin);
  c_count: cover property (count_en_ch0);
  c_pwm: cover property (pin_func_d == TPS_FN_PWM);
  c_ext: cover property (count_en_ch1 && clock_source_sel_ch1 == 3'h5);
endmodule

bind tps_top tps_top_assertions u_chk (.*);

// ### dv/tps_top_test.sv
// Purpose: Self-checking bench for tps_top
// Assumes: Inputs driven at falling edge
// Notes: Counts of count enables checked over fixed windows
`define CHK(n, e, s) begin samples_checked++; \
  if ((s) !== (e)) begin n_errors++; \
  $display("[ERR] %s exp %0h got %0h", n, e, s); end end
module tps_top_test
  import tps_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0, ext_interrupt_pin = 1'b1;
  logic arst_n, od_wr_en, fixed_period_pwm_select, pwm_mode_select_b;
  logic pwm_mode_select_c, pwm_mode_select_d, cutoff_input_enable;
  logic int_edge_mode_sel, ext_irq_enable, irq_pin_direction, tick_on;
  logic ext_clock_enable, fast_osc_enable, fast_osc_tick;
  logic ext_count_clock_pin, cutoff_mode, count_en_ch0, count_en_ch1;
  logic [1:0] combo_mode_field, ext_clock_edge_sel_ch0, ext_clock_edge_sel_ch1;
  logic [2:0] io_ctrl_a, io_ctrl_b, io_ctrl_c, io_ctrl_d;
  logic [2:0] clock_source_sel_ch0, clock_source_sel_ch1;
  logic [3:0] od_wr_data, timer_output_disable_reg, pin_out_en;
  logic [4:0] div_tick;
  logic [7:0] tcnt = 8'h0;
  tps_func_e pin_func_a, pin_func_b, pin_func_c, pin_func_d;
  int c0, c1, n_errors = 0, samples_checked = 0;
  int dv[8] = '{64, 32, 16, 8, 2, 0, 16, 0};

  tps_top u_dut (.*);
  tps_ext_src u_src (.sys_clk(sys_clk), .pin(ext_count_clock_pin));

  always #2.5 sys_clk = ~sys_clk;
  always @(negedge sys_clk) begin
    tcnt <= tcnt + 8'h1;
    c0 += count_en_ch0;
    c1 += count_en_ch1;
  end
  assign div_tick = tick_on ? {tcnt[4:0] == 5'h0, tcnt[2:0] == 3'h0,
    tcnt[1:0] == 2'h0, tcnt[0], 1'b1} : 5'h0;
  assign fast_osc_tick = tick_on && tcnt[1:0] == 2'h1;

  task automatic cyc(int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic wod(logic [3:0] v);
    od_wr_en = 1'b1;
    od_wr_data = v;
    cyc(1);
    od_wr_en = 1'b0;
  endtask
  function automatic tps_func_e ef(logic od, hp, p, logic [2:0] io);
    logic tmm;
    tmm = fixed_period_pwm_select && combo_mode_field == 2'h0;
    if (tmm && !(hp && p) && io[2]) return TPS_FN_IC;
    if (od) return TPS_FN_PORT;
    if (combo_mode_field[1]) return TPS_FN_COMP;
    if (combo_mode_field[0]) return TPS_FN_RSYNC;
    if (!tmm) return TPS_FN_PORT;
    if (hp && p) return TPS_FN_PWM;
    return io != 3'h0 ? TPS_FN_OC : TPS_FN_PORT;
  endfunction
  task automatic cp(string n, tps_func_e f, logic oe, od, hp, p,
      logic [2:0] io);
    tps_func_e e;
    e = ef(od, hp, p, io);
    `CHK(n, e, f)
    `CHK(n, e != TPS_FN_PORT && e != TPS_FN_IC, oe)
  endtask
  task automatic cnt(int e0, int e1, int np);
    c0 = 0;
    c1 = 0;
    tick_on = 1'b1;
    fork
      cyc(64);
      u_src.burst(np);
    join
    tick_on = 1'b0;
    cyc(8);
    `CHK("count_ch0", e0, c0)
    `CHK("count_ch1", e1, c1)
  endtask
  task results;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #100000;
    n_errors++;
    results;
  end

  initial begin
    {arst_n, od_wr_en, fixed_period_pwm_select, combo_mode_field,
      pwm_mode_select_b, pwm_mode_select_c, pwm_mode_select_d, io_ctrl_a,
      io_ctrl_b, io_ctrl_c, io_ctrl_d, cutoff_input_enable,
      int_edge_mode_sel, ext_irq_enable, irq_pin_direction,
      clock_source_sel_ch0, clock_source_sel_ch1, ext_clock_edge_sel_ch0,
      ext_clock_edge_sel_ch1, ext_clock_enable, fast_osc_enable,
      od_wr_data, tick_on} = '0;
    cyc(6);
    `CHK("od_reset", 4'hf, timer_output_disable_reg)
    `CHK("func_reset", TPS_FN_PORT, pin_func_b)
    arst_n = 1'b1;
    cyc(1);
    // Capture pins stay inputs on the pin side
    for (int o = 0; o < 2; o++) begin
      wod({4{o[0]}});
      `CHK("od_write", {4{o[0]}}, timer_output_disable_reg)
      for (int k = 0; k < 128; k++) begin
        {fixed_period_pwm_select, combo_mode_field, pwm_mode_select_b,
          io_ctrl_a} = k[6:0];
        pwm_mode_select_c = pwm_mode_select_b;
        pwm_mode_select_d = !pwm_mode_select_b;
        io_ctrl_b = io_ctrl_a + 3'h1;
        io_ctrl_c = io_ctrl_a + 3'h2;
        io_ctrl_d = io_ctrl_a + 3'h3;
        cyc(2);
        cp("func_a", pin_func_a, pin_out_en[0], o[0], 0, 0,
          io_ctrl_a);
        cp("func_b", pin_func_b, pin_out_en[1], o[0], 1, pwm_mode_select_b,
          io_ctrl_b);
        cp("func_c", pin_func_c, pin_out_en[2], o[0], 1, pwm_mode_select_c,
          io_ctrl_c);
        cp("func_d", pin_func_d, pin_out_en[3], o[0], 1, pwm_mode_select_d,
          io_ctrl_d);
      end
    end
    // Each enable broken in turn, then all set
    combo_mode_field = 2'h2;
    for (int k = 0; k < 5; k++) begin
      {cutoff_input_enable, int_edge_mode_sel, ext_irq_enable,
        irq_pin_direction} = 4'ha ^ (k < 4 ? 4'h1 << k : 4'h0);
      wod(4'h0);
      ext_interrupt_pin = 1'b0;
      cyc(2);
      `CHK("cut_mode", k == 4, cutoff_mode)
      `CHK("od_cut", {4{k == 4}}, timer_output_disable_reg)
      `CHK("oe_cut", {4{k != 4}}, pin_out_en)
      ext_interrupt_pin = 1'b1;
    end
    // Cutoff and software clear in one cycle: cutoff wins
    ext_interrupt_pin = 1'b0;
    wod(4'h0);
    `CHK("od_cut_wr", 4'hf, timer_output_disable_reg)
    ext_interrupt_pin = 1'b1;
    {cutoff_input_enable, ext_irq_enable, combo_mode_field} = '0;
    fixed_period_pwm_select = 1'b1;
    fast_osc_enable = 1'b1;
    for (int s = 0; s < 8; s++) begin
      clock_source_sel_ch0 = s[2:0];
      clock_source_sel_ch1 = s[2:0];
      cnt(dv[s], dv[s], 0);
    end
    fast_osc_enable = 1'b0;
    clock_source_sel_ch0 = 3'h6;
    clock_source_sel_ch1 = 3'h6;
    cnt(0, 0, 0);
    clock_source_sel_ch0 = 3'h5;
    clock_source_sel_ch1 = 3'h5;
    ext_clock_enable = 1'b1;
    for (int e = 0; e < 4; e++) begin
      ext_clock_edge_sel_ch0 = e[1:0];
      ext_clock_edge_sel_ch1 = e[1:0];
      cnt(5 << (e >> 1), 5 << (e >> 1), 5);
    end
    fixed_period_pwm_select = 1'b0;
    cnt(0, 0, 5);
    fixed_period_pwm_select = 1'b1;
    ext_clock_enable = 1'b0;
    cnt(0, 0, 5);
    results;
  end
endmodule

// ### hw/tps_ext_edge.sv
// Purpose: Synchronise the external count clock and detect its edge
// Assumes: Pin is asynchronous to sys_clk
// Notes: A change counts once the second and third stages agree
`include "tps_params.svh"

module tps_ext_edge
  import tps_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic pin,
  input wire logic [1:0] edge_sel,
  output logic edge_pulse
);

  tps_edge_s st_r;
  tps_edge_s st_nxt;

  always_comb begin
    logic rise;
    logic fall;
    rise = 1'b0;
    fall = 1'b0;
    st_nxt = st_r;
    st_nxt.s1 = pin;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    st_nxt.pulse = 1'b0;
    if (st_r.s2 == st_r.s3) begin  // [RULE_15]
      rise = st_r.s2 & ~st_r.level;
      fall = ~st_r.s2 & st_r.level;
      st_nxt.level = st_r.s2;
    end
    case (edge_sel)  // [RULE_11]
      `TPS_EDGE_RISE: st_nxt.pulse = rise;
      `TPS_EDGE_FALL: st_nxt.pulse = fall;
      default: st_nxt.pulse = rise | fall;
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign edge_pulse = st_r.pulse;

endmodule

// ### hw/tps_params.svh
// Purpose: Constants for the timer pin function and clock select block
// Assumes: Included by the design modules tps_ext_edge and tps_top
// Notes: Encodings of selection fields and reset values
`ifndef TPS_PARAMS_SVH
`define TPS_PARAMS_SVH

// Combination mode field
`define TPS_CMD_NONE 2'h0
`define TPS_CMD_RSYNC 2'h1

// Io control field, bit 2 set selects capture input
`define TPS_IO_OC_A 3'h1
`define TPS_IO_IC_BIT 2

// Clock source select codes
`define TPS_CK_F1 3'h0
`define TPS_CK_F2 3'h1
`define TPS_CK_F4 3'h2
`define TPS_CK_F8 3'h3
`define TPS_CK_F32 3'h4
`define TPS_CK_EXT 3'h5
`define TPS_CK_FOSC 3'h6

// External clock edge select
`define TPS_EDGE_RISE 2'h0
`define TPS_EDGE_FALL 2'h1

// Output disable bits come out of reset disabled
`define TPS_OD_RESET 4'hf

// Least external clock pulse, in timer clock cycles
`define TPS_EXT_MIN_PULSE 3

`endif

// ### hw/tps_pkg.sv
// Purpose: Types for the timer pin function and clock select block
// Assumes: tps_params.svh holds the numeric constants
// Notes: Pin function codes are the decoded pin roles
package tps_pkg;

  typedef enum logic [2:0] {
    TPS_FN_PORT = 3'h0,
    TPS_FN_COMP = 3'h1,
    TPS_FN_RSYNC = 3'h2,
    TPS_FN_PWM = 3'h3,
    TPS_FN_OC = 3'h4,
    TPS_FN_IC = 3'h5
  } tps_func_e;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
    logic pulse;
  } tps_edge_s;

  typedef struct packed {
    logic [3:0] od;
    tps_func_e fa;
    tps_func_e fb;
    tps_func_e fc;
    tps_func_e fd;
    logic [3:0] oe;
    logic cut;
    logic [1:0] cnt;
  } tps_top_s;

endpackage

// ### hw/tps_top.sv
// Purpose: Channel-1 timer pin function decode and count source select
// Assumes: Selection bits are static levels on sys_clk; the interrupt
//   pin level arrives already filtered on sys_clk
// Notes: All outputs are registered, one cycle after the inputs; pin roles two after an od write or cutoff, counts five after the count pin
//
// Contract
// (RULE_01) Combo modes output complementary or reset-sync PWM
// (RULE_02) Timer mode selects output compare waveform
// (RULE_03) Io control 1XX selects capture trigger input
// (RULE_04) PWM select bit gives PWM waveform output
// (RULE_05) Anything else leaves pin as port
// (RULE_06) Interrupt pin becomes cutoff input when enabled
// (RULE_07) Software sets capture pins as inputs
// (RULE_08) External clock unusable in fixed period mode
// (RULE_09) Source field picks f1 f2 f4 f8 f32
// (RULE_10) Code 110 with fast osc enable
// (RULE_11) Code 101 counts selected external edges
// (RULE_12) External pulses last three clock cycles
// (RULE_13) Software enables fast osc before selecting
// (RULE_14) Low cutoff input disables all outputs quickly
// (RULE_15) External clock synchronised, one pulse per edge
// (RULE_16) Decode combinational, effective next clock
`include "tps_params.svh"

module tps_top
  import tps_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic od_wr_en,
  input wire logic [3:0] od_wr_data,
  input wire logic fixed_period_pwm_select,
  input wire logic [1:0] combo_mode_field,
  input wire logic pwm_mode_select_b,
  input wire logic pwm_mode_select_c,
  input wire logic pwm_mode_select_d,
  input wire logic [2:0] io_ctrl_a,
  input wire logic [2:0] io_ctrl_b,
  input wire logic [2:0] io_ctrl_c,
  input wire logic [2:0] io_ctrl_d,
  input wire logic cutoff_input_enable,
  input wire logic int_edge_mode_sel,
  input wire logic ext_irq_enable,
  input wire logic irq_pin_direction,
  input wire logic ext_interrupt_pin,
  input wire logic [2:0] clock_source_sel_ch0,
  input wire logic [2:0] clock_source_sel_ch1,
  input wire logic [1:0] ext_clock_edge_sel_ch0,
  input wire logic [1:0] ext_clock_edge_sel_ch1,
  input wire logic ext_clock_enable,
  input wire logic fast_osc_enable,
  input wire logic [4:0] div_tick,
  input wire logic fast_osc_tick,
  input wire logic ext_count_clock_pin,
  output logic [3:0] timer_output_disable_reg,
  output tps_func_e pin_func_a,
  output tps_func_e pin_func_b,
  output tps_func_e pin_func_c,
  output tps_func_e pin_func_d,
  output logic [3:0] pin_out_en,
  output logic cutoff_mode,
  output logic count_en_ch0,
  output logic count_en_ch1
);

  tps_top_s st_r;
  tps_top_s st_nxt;
  logic ext_pulse_ch0;
  logic ext_pulse_ch1;

  // Decode one channel-1 pin; pwm_ok is 0 for the pin with no PWM bit
  function automatic tps_func_e pin_decode(
    input logic od,
    input logic fps,
    input logic [1:0] cmd,
    input logic pwm_ok,
    input logic pwm_sel,
    input logic [2:0] io
  );
    tps_func_e f;
    f = TPS_FN_PORT;  // [RULE_05]
    if (!od && cmd[1]) begin
      f = TPS_FN_COMP;  // [RULE_01]
    end else if (!od && cmd == `TPS_CMD_RSYNC) begin
      f = TPS_FN_RSYNC;  // [RULE_01]
    end else if (fps && cmd == `TPS_CMD_NONE) begin
      if (pwm_ok && pwm_sel) begin
        if (!od) begin
          f = TPS_FN_PWM;  // [RULE_04]
        end
      end else if (io[`TPS_IO_IC_BIT]) begin
        f = TPS_FN_IC;  // [RULE_03]
      end else if (!od && io != 3'h0) begin
        f = TPS_FN_OC;  // [RULE_02]
      end
    end
    return f;
  endfunction

  // Count enable for one channel from its source field
  function automatic logic src_pick(
    input logic [2:0] sel,
    input logic [4:0] ticks,
    input logic ext_ok,
    input logic ext_pulse,
    input logic fosc_ok,
    input logic fosc_tick
  );
    logic en;
    en = 1'b0;
    case (sel)
      `TPS_CK_F1: en = ticks[0];  // [RULE_09]
      `TPS_CK_F2: en = ticks[1];  // [RULE_09]
      `TPS_CK_F4: en = ticks[2];  // [RULE_09]
      `TPS_CK_F8: en = ticks[3];  // [RULE_09]
      `TPS_CK_F32: en = ticks[4];  // [RULE_09]
      `TPS_CK_EXT: en = ext_ok & ext_pulse;  // [RULE_11]
      `TPS_CK_FOSC: en = fosc_ok & fosc_tick;  // [RULE_10]
      default: en = 1'b0;
    endcase
    return en;
  endfunction

  tps_ext_edge u_edge_ch0 (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .pin(ext_count_clock_pin),
    .edge_sel(ext_clock_edge_sel_ch0),
    .edge_pulse(ext_pulse_ch0)
  );

  tps_ext_edge u_edge_ch1 (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .pin(ext_count_clock_pin),
    .edge_sel(ext_clock_edge_sel_ch1),
    .edge_pulse(ext_pulse_ch1)
  );

  always_comb begin
    logic cut_on;
    logic fp3_mode;
    logic ext_ok;
    logic [3:0] od;
    cut_on = 1'b0;
    fp3_mode = 1'b0;
    ext_ok = 1'b0;
    od = 4'h0;
    st_nxt = st_r;

    // Interrupt pin acts as cutoff input only in this setup
    cut_on = cutoff_input_enable & ~int_edge_mode_sel &
             ext_irq_enable & ~irq_pin_direction;  // [RULE_06]
    st_nxt.cut = cut_on;

    // Software write, then cutoff set wins over any clear
    od = st_r.od;
    if (od_wr_en) begin
      od = od_wr_data;
    end
    if (cut_on && !ext_interrupt_pin) begin
      od = 4'hf;  // [RULE_14]
    end
    st_nxt.od = od;

    // Decode from present bits; result visible next cycle
    st_nxt.fa = pin_decode(st_r.od[0], fixed_period_pwm_select,
                           combo_mode_field, 1'b0, 1'b0,
                           io_ctrl_a);  // [RULE_16]
    st_nxt.fb = pin_decode(st_r.od[1], fixed_period_pwm_select,
                           combo_mode_field, 1'b1, pwm_mode_select_b,
                           io_ctrl_b);  // [RULE_16]
    st_nxt.fc = pin_decode(st_r.od[2], fixed_period_pwm_select,
                           combo_mode_field, 1'b1, pwm_mode_select_c,
                           io_ctrl_c);  // [RULE_16]
    st_nxt.fd = pin_decode(st_r.od[3], fixed_period_pwm_select,
                           combo_mode_field, 1'b1, pwm_mode_select_d,
                           io_ctrl_d);  // [RULE_16]

    // Pin drives whenever its decoded role is a waveform output
    st_nxt.oe[0] = st_nxt.fa != TPS_FN_PORT && st_nxt.fa != TPS_FN_IC;
    st_nxt.oe[1] = st_nxt.fb != TPS_FN_PORT && st_nxt.fb != TPS_FN_IC;
    st_nxt.oe[2] = st_nxt.fc != TPS_FN_PORT && st_nxt.fc != TPS_FN_IC;
    st_nxt.oe[3] = st_nxt.fd != TPS_FN_PORT && st_nxt.fd != TPS_FN_IC;

    // Fixed period mode blocks the external clock
    fp3_mode = ~fixed_period_pwm_select &
               (combo_mode_field == `TPS_CMD_NONE);
    ext_ok = ext_clock_enable & ~fp3_mode;  // [RULE_08]
    st_nxt.cnt[0] = src_pick(clock_source_sel_ch0, div_tick, ext_ok,
                             ext_pulse_ch0, fast_osc_enable,
                             fast_osc_tick);  // [RULE_10]
    st_nxt.cnt[1] = src_pick(clock_source_sel_ch1, div_tick, ext_ok,
                             ext_pulse_ch1, fast_osc_enable,
                             fast_osc_tick);  // [RULE_11]
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r.od <= `TPS_OD_RESET;
      st_r.fa <= TPS_FN_PORT;
      st_r.fb <= TPS_FN_PORT;
      st_r.fc <= TPS_FN_PORT;
      st_r.fd <= TPS_FN_PORT;
      st_r.oe <= 4'h0;
      st_r.cut <= 1'b0;
      st_r.cnt <= 2'h0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign timer_output_disable_reg = st_r.od;
  assign pin_func_a = st_r.fa;
  assign pin_func_b = st_r.fb;
  assign pin_func_c = st_r.fc;
  assign pin_func_d = st_r.fd;
  assign pin_out_en = st_r.oe;
  assign cutoff_mode = st_r.cut;
  assign count_en_ch0 = st_r.cnt[0];
  assign count_en_ch1 = st_r.cnt[1];

endmodule
